// [pkg/iop_params.svh]
`ifndef IOP_PARAMS_SVH
`define IOP_PARAMS_SVH

// register indices, byte address is four times the index
`define IOP_IDX_DIR 16'hFFCD
`define IOP_IDX_IN 16'hFFCE
`define IOP_IDX_DAT 16'hFFCF
`define IOP_IDX_LSB 2

// bus geometry
`define IOP_ADDR_W 18
`define IOP_DATA_W 32
`define IOP_REG_W 8

// reset values, direction read value and fixed ones
`define IOP_DIR_RST 8'hE0
`define IOP_DAT_RST 8'hE0
`define IOP_DIR_READ 8'hFF
`define IOP_FIXED_ONES 8'hE0

// spare bit position, pin counts and store width
`define IOP_SPARE_BIT 4
`define IOP_IO_PINS 4
`define IOP_IN_PINS 8
`define IOP_STORE_W 5

// synchroniser depth
`define IOP_SYNC_STAGES 2

`endif

// [pkg/iop_pkg.sv]
`include "iop_params.svh"

package iop_pkg;

   typedef enum logic [0:0] {
      IOP_ST_IDLE = 1'b0,
      IOP_ST_ACCESS = 1'b1
   } iop_bus_state_t;

   typedef enum logic [1:0] {
      IOP_SEL_NONE = 2'b00,
      IOP_SEL_DIR = 2'b01,
      IOP_SEL_IN = 2'b10,
      IOP_SEL_DAT = 2'b11
   } iop_sel_t;

   typedef struct packed {
      logic [`IOP_STORE_W-1:0] dir;
      logic [`IOP_STORE_W-1:0] dat;
   } iop_pin_cfg_t;

   typedef struct packed {
      logic [`IOP_REG_W-1:0] rdata;
      logic err;
   } iop_answer_t;

endpackage : iop_pkg

// [core/iop_sync.sv]
`include "iop_params.svh"

module iop_sync import iop_pkg::*; #(
   parameter int WIDTH = 1,
   parameter logic RST_VAL = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   if (WIDTH < 1) begin : g_bad_width
      $error("iop_sync: WIDTH must be at least 1");
   end

   // first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {WIDTH{RST_VAL}};
         sync_q <= {WIDTH{RST_VAL}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule : iop_sync

// [core/iop_pin_drive.sv]
`include "iop_params.svh"

module iop_pin_drive import iop_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire iop_pin_cfg_t cfg,
   input wire logic hw_stby,
   input wire logic [`IOP_IO_PINS-1:0] pin_lvl,
   output logic [`IOP_IO_PINS-1:0] pin_out,
   output logic [`IOP_IO_PINS-1:0] pin_oe_n,
   output logic [`IOP_IO_PINS-1:0] intreq_n
);

   logic [`IOP_IO_PINS-1:0] out_d;
   logic [`IOP_IO_PINS-1:0] out_q;
   logic [`IOP_IO_PINS-1:0] oe_n_d;
   logic [`IOP_IO_PINS-1:0] oe_n_q;
   logic [`IOP_IO_PINS-1:0] irq_d;
   logic [`IOP_IO_PINS-1:0] irq_q;

   genvar i;
   generate
      for (i = 0; i < `IOP_IO_PINS; i++) begin : g_pin
         always_comb begin
            out_d[i] = cfg.dat[i];
            // drive only with direction set; hardware standby floats all pins
            oe_n_d[i] = ~(cfg.dir[i] & ~hw_stby);
            // interrupt path sees the pin whatever its direction
            irq_d[i] = pin_lvl[i];
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= '0;
         oe_n_q <= '1;
         irq_q <= '1;
      end else begin
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         irq_q <= irq_d;
      end
   end

   assign pin_out = out_q;
   assign pin_oe_n = oe_n_q;
   assign intreq_n = irq_q;

endmodule : iop_pin_drive

// [core/iop_port_top.sv]
// Our own choice: the APB interface to the registers.
`include "iop_params.svh"

// Operation
// - the input level register at index 0xFFCE returns the present input pin levels, never a stored value.
// - the eight input pins have no direction control and no direction register.
// - the second port has four pins for input or output, each also an active-low interrupt request input.
// - the write-only direction register at index 0xFFCD loads 0xE0 on reset and hardware standby, bits 7 to 5 at one.
// - reading the direction register returns all ones whatever was written.
// - a pin of the second port drives its data bit when its direction bit is one and is an input otherwise.
// - in software standby the direction register keeps its value and driven pins keep driving.
// - the data register at index 0xFFCF holds output data for pins 3 to 0 and loads 0xE0 on reset and hardware standby.
// - a data register read gives the stored bit where the direction bit is one and the pin level where it is zero.
// - data register bits 7 to 5 ignore writes and read as one.
// - data bit 4 is writable, drives no pin, and reads back only when direction bit 4 is one, else one.
// - the data register keeps its contents during software standby.
module iop_port_top import iop_pkg::*; #(
   parameter int ADDR_W = `IOP_ADDR_W,
   parameter int IN_W = `IOP_IN_PINS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [`IOP_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [`IOP_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [IN_W-1:0] input_pins,
   input wire logic [`IOP_IO_PINS-1:0] io_pin_in,
   output logic [`IOP_IO_PINS-1:0] io_pin_out,
   output logic [`IOP_IO_PINS-1:0] io_pin_oe_n,
   output logic intreq_in0_n,
   output logic intreq_in1_n,
   output logic intreq_in2_n,
   output logic intreq_in3_n,
   input wire logic hw_stby_n,
   input wire logic sw_stby
);

   localparam int SYNC_W = IN_W + `IOP_IO_PINS + 1;

   // elaboration guards: decode needs the whole index, the read view one byte
   if (ADDR_W < `IOP_IDX_LSB + 16) begin : g_bad_addr_w
      $error("iop_port_top: ADDR_W too small for the register indices");
   end
   if (IN_W < 1 || IN_W > `IOP_REG_W) begin : g_bad_in_w
      $error("iop_port_top: IN_W must lie between 1 and the register width");
   end
   if (`IOP_STORE_W <= `IOP_SPARE_BIT || `IOP_IO_PINS > `IOP_SPARE_BIT) begin : g_bad_store_w
      $error("iop_port_top: stored bits must cover the pins and the spare bit");
   end
   if (`IOP_DATA_W < `IOP_REG_W) begin : g_bad_data_w
      $error("iop_port_top: bus narrower than one register");
   end

   // synchronised pins

   logic [SYNC_W-1:0] sync_raw;
   logic [SYNC_W-1:0] sync_lvl;
   logic [IN_W-1:0] in_lvl;
   logic [`IOP_IO_PINS-1:0] io_lvl;
   logic hw_stby;

   assign sync_raw = {hw_stby_n, io_pin_in, input_pins};

   // every pin crosses into pclk before any logic sees it
   iop_sync #(
      .WIDTH(SYNC_W),
      .RST_VAL(1'b1)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(sync_raw),
      .sync_out(sync_lvl)
   );

   assign in_lvl = sync_lvl[IN_W-1:0];
   assign io_lvl = sync_lvl[IN_W +: `IOP_IO_PINS];
   assign hw_stby = ~sync_lvl[SYNC_W-1];

   // address decode, shared by read and write paths

   function automatic iop_sel_t iop_decode(input logic [ADDR_W-1:0] addr);
      logic [15:0] idx;
      idx = addr[`IOP_IDX_LSB +: 16];
      iop_decode = IOP_SEL_NONE;
      if (addr[`IOP_IDX_LSB-1:0] != '0) begin
         iop_decode = IOP_SEL_NONE;
      end else if ((addr >> (`IOP_IDX_LSB + 16)) != '0) begin
         iop_decode = IOP_SEL_NONE;
      end else if (idx == `IOP_IDX_DIR) begin
         iop_decode = IOP_SEL_DIR;
      end else if (idx == `IOP_IDX_IN) begin
         iop_decode = IOP_SEL_IN;
      end else if (idx == `IOP_IDX_DAT) begin
         iop_decode = IOP_SEL_DAT;
      end
   endfunction : iop_decode

   // read view of the data register
   function automatic logic [`IOP_REG_W-1:0] iop_dat_view(
      input logic [`IOP_STORE_W-1:0] dir,
      input logic [`IOP_STORE_W-1:0] dat,
      input logic [`IOP_IO_PINS-1:0] lvl
   );
      logic [`IOP_REG_W-1:0] v;
      v = `IOP_FIXED_ONES;
      for (int b = 0; b < `IOP_IO_PINS; b++) begin
         v[b] = dir[b] ? dat[b] : lvl[b];
      end
      // spare bit has no pin behind it
      v[`IOP_SPARE_BIT] = dir[`IOP_SPARE_BIT] ? dat[`IOP_SPARE_BIT] : 1'b1;
      iop_dat_view = v;
   endfunction : iop_dat_view

   // bus handshake

   iop_bus_state_t st_q;
   iop_bus_state_t st_d;
   logic rdy_q;
   logic rdy_d;
   iop_answer_t ans_q;
   iop_answer_t ans_d;
   iop_sel_t sel;
   logic setup;
   logic commit;

   assign sel = iop_decode(paddr);
   assign setup = psel & ~penable;
   assign commit = psel & penable & rdy_q;

   // registers

   logic [`IOP_STORE_W-1:0] dir_q;
   logic [`IOP_STORE_W-1:0] dir_d;
   logic [`IOP_STORE_W-1:0] dat_q;
   logic [`IOP_STORE_W-1:0] dat_d;
   logic wr_ok;

   // answer prepared in setup, so read data leaves a flop
   always_comb begin
      st_d = st_q;
      rdy_d = 1'b0;
      ans_d = ans_q;
      case (st_q)
         IOP_ST_IDLE: begin
            if (setup) begin
               st_d = IOP_ST_ACCESS;
               rdy_d = 1'b1;
               ans_d.err = 1'b0;
               ans_d.rdata = '0;
               case (sel)
                  IOP_SEL_DIR: begin
                     ans_d.rdata = `IOP_DIR_READ;
                  end
                  IOP_SEL_IN: begin
                     // live synchronised levels, nothing stored
                     ans_d.rdata = `IOP_REG_W'(in_lvl);
                     ans_d.err = pwrite;
                  end
                  IOP_SEL_DAT: begin
                     ans_d.rdata = iop_dat_view(dir_q, dat_q, io_lvl);
                  end
                  default: begin
                     ans_d.err = 1'b1;
                  end
               endcase
               if (pwrite) begin
                  ans_d.rdata = '0;
               end
            end
         end
         IOP_ST_ACCESS: begin
            rdy_d = 1'b0;
            if (commit) begin
               st_d = IOP_ST_IDLE;
            end else begin
               rdy_d = 1'b1;
            end
         end
         default: begin
            st_d = IOP_ST_IDLE;
            rdy_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= IOP_ST_IDLE;
         rdy_q <= 1'b0;
         ans_q <= '0;
      end else begin
         st_q <= st_d;
         rdy_q <= rdy_d;
         ans_q <= ans_d;
      end
   end

   // writes land only at the completing edge, never in standby
   assign wr_ok = commit & pwrite & ~ans_q.err & pstrb[0] & ~sw_stby & ~hw_stby;

   logic wr_dir;
   logic wr_dat;

   assign wr_dir = wr_ok & (sel == IOP_SEL_DIR);
   assign wr_dat = wr_ok & (sel == IOP_SEL_DAT);

   // direction store: bits 7 to 5 are not stored, they are constant ones
   always_comb begin
      dir_d = dir_q;
      if (hw_stby) begin
         dir_d = `IOP_STORE_W'(`IOP_DIR_RST);
      end else if (wr_dir) begin
         dir_d = pwdata[`IOP_STORE_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= `IOP_STORE_W'(`IOP_DIR_RST);
      end else begin
         dir_q <= dir_d;
      end
   end

   // data store: bit 4 has no pin, it only feeds the read view
   always_comb begin
      dat_d = dat_q;
      if (hw_stby) begin
         dat_d = `IOP_STORE_W'(`IOP_DAT_RST);
      end else if (wr_dat) begin
         dat_d = pwdata[`IOP_STORE_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dat_q <= `IOP_STORE_W'(`IOP_DAT_RST);
      end else begin
         dat_q <= dat_d;
      end
   end

   // pin drive and interrupt requests

   iop_pin_cfg_t cfg;
   logic [`IOP_IO_PINS-1:0] irq_n;

   assign cfg = '{dir: dir_q, dat: dat_q};

   // no guard on pins 3 to 0: a set direction bit does drive
   iop_pin_drive u_pins (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg),
      .hw_stby(hw_stby),
      .pin_lvl(io_lvl),
      .pin_out(io_pin_out),
      .pin_oe_n(io_pin_oe_n),
      .intreq_n(irq_n)
   );

   assign intreq_in0_n = irq_n[0];
   assign intreq_in1_n = irq_n[1];
   assign intreq_in2_n = irq_n[2];
   assign intreq_in3_n = irq_n[3];

   // bus outputs, each from a flop; error must not leak past the access cycle

   logic [`IOP_DATA_W-1:0] prdata_q;
   logic [`IOP_DATA_W-1:0] prdata_d;
   logic slverr_q;
   logic slverr_d;

   always_comb begin
      prdata_d = `IOP_DATA_W'(ans_d.rdata);
      slverr_d = rdy_d & ans_d.err;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         slverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = rdy_q;
   assign pslverr = slverr_q;

endmodule : iop_port_top

// [verif/iop_port_properties.sv]
module iop_port_properties #(
   parameter int ADDR_W = 18,
   parameter int IN_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [IN_W-1:0] input_pins,
   input wire logic [3:0] io_pin_in,
   input wire logic [3:0] io_pin_out,
   input wire logic [3:0] io_pin_oe_n,
   input wire logic intreq_in0_n,
   input wire logic intreq_in1_n,
   input wire logic intreq_in2_n,
   input wire logic intreq_in3_n,
   input wire logic hw_stby_n,
   input wire logic sw_stby
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [ADDR_W-1:0] A_DIR = 18'h3FF34;
   localparam logic [ADDR_W-1:0] A_IN = 18'h3FF38;
   localparam logic [ADDR_W-1:0] A_DAT = 18'h3FF3C;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_read(a);
      s_setup ##0 (!pwrite && paddr == a);
   endsequence
   property p_dir_read;
      s_read(A_DIR) |=> prdata[7:0] == 8'hFF && !pslverr;
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("direction read not all ones");
   property p_upper_ones;
      s_read(A_DAT) |=> prdata[7:5] == 3'h7 && prdata[31:8] == 24'h0;
   endproperty
   a_upper_ones: assert property (p_upper_ones) else $error("data upper bits wrong");
   property p_in_write_err;
      s_setup ##0 (pwrite && paddr == A_IN) |=> pready && pslverr;
   endproperty
   a_in_write_err: assert property (p_in_write_err) else $error("input write not refused");
   // pins held still long enough to cross both flops
   property p_in_read;
      $stable(input_pins)[*4] ##0 s_read(A_IN) |=> prdata[7:0] == $past(input_pins);
   endproperty
   a_in_read: assert property (p_in_read) else $error("input read not live");
   property p_data_pins;
      $stable(io_pin_in)[*4] ##0 s_read(A_DAT) |=> io_pin_oe_n != 4'hF || prdata[3:0] == $past(io_pin_in);
   endproperty
   a_data_pins: assert property (p_data_pins) else $error("data read misses pin level");
   property p_irq_follow;
      // one cycle beyond the path, so the release edge cannot start an attempt
      $stable(io_pin_in)[*5] |-> {intreq_in3_n, intreq_in2_n, intreq_in1_n, intreq_in0_n} == io_pin_in;
   endproperty
   a_irq_follow: assert property (p_irq_follow) else $error("request lines lag pins");
   property p_sw_hold;
      (sw_stby && hw_stby_n)[*5] |-> $stable(io_pin_out) && $stable(io_pin_oe_n);
   endproperty
   a_sw_hold: assert property (p_sw_hold) else $error("outputs moved in standby");
   property p_hw_release;
      (!hw_stby_n)[*6] |-> io_pin_oe_n == 4'hF;
   endproperty
   a_hw_release: assert property (p_hw_release) else $error("pin driven in hw standby");
endmodule : iop_port_properties

bind iop_port_top iop_port_properties #(.ADDR_W(ADDR_W), .IN_W(IN_W)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_pins(input_pins), .io_pin_in(io_pin_in),
   .io_pin_out(io_pin_out), .io_pin_oe_n(io_pin_oe_n), .intreq_in0_n(intreq_in0_n),
   .intreq_in1_n(intreq_in1_n), .intreq_in2_n(intreq_in2_n), .intreq_in3_n(intreq_in3_n),
   .hw_stby_n(hw_stby_n), .sw_stby(sw_stby)
);

// [verif/iop_board_model.sv]
module iop_board_model (
   input wire logic [3:0] io_pin_out,
   input wire logic [3:0] io_pin_oe_n,
   input wire logic [3:0] board_lvl,
   output logic [3:0] io_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // board always holds a level, device wins where it drives
   assign io_pin_in = (io_pin_oe_n & board_lvl) | (~io_pin_oe_n & io_pin_out);
endmodule : iop_board_model

// [verif/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [17:0] A_DIR = 18'h3FF34;
   localparam logic [17:0] A_IN = 18'h3FF38;
   localparam logic [17:0] A_DAT = 18'h3FF3C;
   typedef struct {
      logic w;
      logic [17:0] a;
      logic [31:0] d;
      logic [31:0] r;
      logic e;
   } iop_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] input_pins = 8'h5C;
   logic [3:0] board_lvl = 4'hA;
   logic hw_stby_n = 1'b1;
   logic sw_stby = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic [3:0] io_pin_in, io_pin_out, io_pin_oe_n;
   wire logic [3:0] irq_n;
   int n_errors = 0;
   int num_checks = 0;
   iop_row_t rows [11] = '{
      '{1'b0, A_DIR, 32'h0, 32'hFF, 1'b0},
      '{1'b0, A_DAT, 32'h0, 32'hFA, 1'b0},
      '{1'b0, A_IN, 32'h0, 32'h5C, 1'b0},
      '{1'b1, A_DIR, 32'h11, 32'h0, 1'b0},
      '{1'b1, A_DAT, 32'h1F, 32'h0, 1'b0},
      '{1'b0, A_DAT, 32'h0, 32'hFB, 1'b0},
      '{1'b1, A_DAT, 32'h2, 32'h0, 1'b0},
      '{1'b0, A_DAT, 32'h0, 32'hEA, 1'b0},
      '{1'b1, A_IN, 32'hFF, 32'h0, 1'b1},
      '{1'b0, 18'h3FF40, 32'h0, 32'h0, 1'b1},
      '{1'b1, 18'h3FF3D, 32'h0, 32'h0, 1'b1}
   };
   iop_port_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_pins(input_pins), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe_n(io_pin_oe_n),
      .intreq_in0_n(irq_n[0]), .intreq_in1_n(irq_n[1]), .intreq_in2_n(irq_n[2]), .intreq_in3_n(irq_n[3]),
      .hw_stby_n(hw_stby_n), .sw_stby(sw_stby)
   );
   iop_board_model u_board (
      .io_pin_out(io_pin_out), .io_pin_oe_n(io_pin_oe_n), .board_lvl(board_lvl), .io_pin_in(io_pin_in)
   );
   always #5 pclk = ~pclk;
   task finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // called just after an edge; answer taken at the edge that sees pready
   task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 11; i++) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk(rd, rows[i].r);
         chk(32'(er), 32'(rows[i].e));
      end
      $display("test table done");
      apb(1'b1, A_DAT, 32'h1);
      repeat (4) @(posedge pclk);
      chk({24'h0, io_pin_oe_n, io_pin_out}, 32'hE1);
      chk({28'h0, irq_n}, 32'hB);
      $display("test drive done");
      sw_stby <= 1'b1;
      apb(1'b1, A_DAT, 32'h0);
      chk(32'(er), 32'h0);
      apb(1'b1, A_DIR, 32'h0);
      repeat (6) @(posedge pclk);
      chk({24'h0, io_pin_oe_n, io_pin_out}, 32'hE1);
      apb(1'b0, A_DAT, 32'h0);
      chk(rd, 32'hEB);
      sw_stby <= 1'b0;
      $display("test sw standby done");
      input_pins <= 8'hA3;
      repeat (3) @(posedge pclk);
      apb(1'b0, A_IN, 32'h0);
      chk(rd, 32'hA3);
      $display("test live input done");
      hw_stby_n <= 1'b0;
      repeat (8) @(posedge pclk);
      chk({24'h0, io_pin_oe_n, io_pin_out}, 32'hF0);
      hw_stby_n <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, A_DAT, 32'h0);
      chk(rd, 32'hFA);
      $display("test hw standby done");
      finish_test;
   end
   // about 84 cycles needed, over thirty times that allowed
   initial begin
      #30000;
      n_errors++;
      $display("watchdog expired");
      finish_test;
   end
endmodule : tb
